/* pkg/rfc_map.svh */
// Register map, field positions, reset values and constants of the block.
// Summary of operation
// - Each of the two ports has its own 8-bit control register, port 0 at 0x80 and port 1 at 0xC0.
// - Bit 6 set counts parity errors on received words; clear holds the counter at zero.
// - Bit 5 set stops acquisition once the receive buffer overflows.
// - In the framed build bit 4 set turns descrambling off, so framed data leaves still scrambled.
// - In the framed build the descramble-off bit matters only while framed capture is on and the framer is in frame.
// - In the Ethernet build bit 4 set bypasses the 8b/10b line decoder.
// - Bits 3:2 pick the source: 00 skips the onboard buffer, 01 uses it, 1x sends test data.
// - In the framed build bit 1 set lets line data through only while the framer is locked; test data (bits 3:2 = 1x) is not gated.
// - In the framed build, while framed capture is on, collected data is descrambled unless descrambling is off.
// - With bit 1 clear the raw line words are captured with no alignment or descrambling.
// - In the Ethernet build bit 1 set makes the block align the received words.
// - Software sets then clears bit 0, and the framer drops its lock and hunts again.
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH

`define RFC_P0_CTRL 8'h80
`define RFC_P1_CTRL 8'hC0
`define RFC_P0_STAT 8'hA0
`define RFC_P1_STAT 8'hE0
`define RFC_CTRL_RST 8'h00
`define RFC_CTRL_MASK 8'h7F
`define RFC_STAT_OVF_BIT 1
`define RFC_PCNT_W 16
`define RFC_FRAME_PATTERN 8'hF6
`define RFC_COMMA_PATTERN 8'hBC
`define RFC_SCR_SEED 7'h7F

`endif

/* pkg/rfc_pkg.sv */
// Types shared by the receive framing control modules.
`include "rfc_map.svh"
package rfc_pkg;

  typedef struct packed {
    logic reserved;
    logic parity_error_count_enable;
    logic halt_on_overflow;
    logic descramble_disable;
    logic [1:0] receive_data_source;
    logic framer_lock_enable;
    logic framer_relock;
  } rfc_ctrl_t;

  typedef struct packed {
    logic [7:0] data;
    logic parity;
  } rfc_line_t;

  typedef enum logic [1:0] {
    RFC_SEARCH = 2'b00,
    RFC_LOCKED = 2'b01,
    RFC_DROP = 2'b11
  } rfc_frm_state_t;

  typedef struct packed {
    rfc_frm_state_t state;
    logic [7:0] prev;
    logic [2:0] off;
    logic [6:0] lfsr;
    logic [7:0] word;
    logic wv;
  } rfc_frm_st_t;

  typedef struct packed {
    rfc_ctrl_t ctrl;
    rfc_line_t sync1;
    rfc_line_t sync2;
    logic [`RFC_PCNT_W-1:0] pcnt;
    logic ovf;
    logic halt;
    logic [7:0] tpat;
  } rfc_port_st_t;

  typedef struct packed {
    rfc_port_st_t [1:0] port;
    logic [31:0] rdata;
    logic err;
  } rfc_top_st_t;

endpackage : rfc_pkg

/* src/rfc_buf.sv */
// Two-entry elastic buffer with valid and ready on both sides.
module rfc_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } rfc_buf_st_t;

  rfc_buf_st_t st_q, st_d;
  logic push, pop;

  assign in_ready = st_q.cnt != 2'h2;
  assign out_valid = st_q.cnt != 2'h0;
  assign out_data = st_q.mem[st_q.rp];

  always_comb begin
    st_d = st_q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      st_d.mem[st_q.wp] = in_data;
      st_d.wp = ~st_q.wp;
    end
    if (pop) begin
      st_d.rp = ~st_q.rp;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 2'h1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  a_buf_hold_word: assert property (@(posedge pclk) disable iff (!presetn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("Buffered word changed while stalled.");

endmodule : rfc_buf

/* src/rfc_framer.sv */
// Word aligner, framer lock and frame-synchronous descrambler for one port.
module rfc_framer import rfc_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Incoming words and controls
  input wire logic [7:0] cur,
  input wire logic [7:0] pattern,
  input wire logic relock,
  input wire logic desc_en,
  // Framed output
  output logic in_frame,
  output logic [7:0] word
);
  rfc_frm_st_t st_q, st_d;
  logic [15:0] win;
  logic [7:0] aligned;
  logic [14:0] scr;

  function automatic logic [14:0] scr_step(input logic [6:0] s);
    logic [6:0] r;
    logic [7:0] k;
    logic b;
    r = s;
    k = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      b = r[6] ^ r[5];
      k[i] = b;
      r = {r[5:0], b};
    end
    return {k, r};
  endfunction : scr_step

  assign in_frame = st_q.wv;
  assign word = st_q.word;

  always_comb begin
    st_d = st_q;
    win = {st_q.prev, cur};
    aligned = win[st_q.off +: 8];
    scr = scr_step(st_q.lfsr);
    st_d.prev = cur;
    st_d.word = aligned;
    st_d.wv = (st_q.state == RFC_LOCKED) && !relock;
    case (st_q.state)
      RFC_SEARCH: begin
        for (int k = 7; k >= 0; k--) begin
          if (win[k +: 8] == pattern) begin
            st_d.off = 3'(k);
            st_d.state = RFC_LOCKED;
            st_d.lfsr = `RFC_SCR_SEED;
          end
        end
      end
      RFC_LOCKED: begin
        if (desc_en) begin
          st_d.word = aligned ^ scr[14:7];
        end
        st_d.lfsr = (aligned == pattern) ? `RFC_SCR_SEED : scr[6:0];
      end
      default: begin
      end
    endcase
    if (relock) begin
      st_d.state = RFC_DROP;
    end else if (st_q.state == RFC_DROP) begin
      st_d.state = RFC_SEARCH;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  sequence s_relock_pulse;
    relock ##1 !relock;
  endsequence

  a_relock_drop_hunt: assert property (@(posedge pclk) disable iff (!presetn)
    s_relock_pulse |-> !in_frame ##1 (st_q.state == RFC_SEARCH && !in_frame))
    else $error("Framer did not drop lock and hunt after relock pulse.");

  a_descr_off_raw: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.state == RFC_LOCKED && !desc_en && !relock
    |=> in_frame && word == $past(aligned))
    else $error("Framed word altered while descrambling is off.");

  a_descr_on_apply: assert property (@(posedge pclk) disable iff (!presetn)
    st_q.state == RFC_LOCKED && desc_en |=> word == $past(aligned ^ scr[14:7]))
    else $error("Framed word not descrambled while enabled.");

endmodule : rfc_framer

/* src/rfc_top.sv */
// Two-port receive framing control with its APB register slave.
module rfc_top import rfc_pkg::*; #(
  parameter bit ETH_BUILD = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line words from the transceivers, one per port
  input wire rfc_line_t [1:0] line_in,
  // Captured data toward the host path
  output logic [1:0] cap_valid,
  input wire logic [1:0] cap_ready,
  output logic [1:0][7:0] cap_data,
  // Steering of the onboard buffer and the line decoder
  output logic [1:0] onboard_buffer_sel,
  output logic [1:0] line_decoder_bypass
);
  rfc_top_st_t st_q, st_d;
  logic [2:0] dec_s;
  logic [2:0] dec_a;
  logic [1:0] perr;
  logic [1:0] acq_valid;
  logic [1:0][7:0] acq_data;
  logic [1:0] buf_ready;
  logic [1:0] desc_en;
  logic [1:0] frm_lock;
  logic [1:0][7:0] frm_word;
  logic [7:0] pattern;

  // Returns {hit, port, status} for a register address.
  function automatic logic [2:0] addr_dec(input logic [7:0] a);
    case (a)
      `RFC_P0_CTRL: return 3'b100;
      `RFC_P1_CTRL: return 3'b110;
      `RFC_P0_STAT: return 3'b101;
      `RFC_P1_STAT: return 3'b111;
      default: return 3'b000;
    endcase
  endfunction : addr_dec

  function automatic logic [31:0] stat_word(input rfc_port_st_t p,
                                            input logic lock);
    return {p.pcnt, 13'h0000, p.halt, p.ovf, lock};
  endfunction : stat_word

  // Framed build hunts for the framing byte, Ethernet build for the comma.
  assign pattern = ETH_BUILD ? `RFC_COMMA_PATTERN : `RFC_FRAME_PATTERN;

  assign pready = 1'b1;
  assign prdata = st_q.rdata;
  assign pslverr = st_q.err;

  // Source selection, framer gating and descrambler enable per port.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      perr[p] = ^{st_q.port[p].sync2.data, st_q.port[p].sync2.parity};
      desc_en[p] = !ETH_BUILD && st_q.port[p].ctrl.framer_lock_enable
                   && !st_q.port[p].ctrl.descramble_disable;
      onboard_buffer_sel[p] =
        st_q.port[p].ctrl.receive_data_source == 2'b01;
      line_decoder_bypass[p] =
        ETH_BUILD && st_q.port[p].ctrl.descramble_disable;
      if (st_q.port[p].ctrl.receive_data_source[1]) begin
        acq_valid[p] = !st_q.port[p].halt;
        acq_data[p] = st_q.port[p].tpat;
      end else if (st_q.port[p].ctrl.framer_lock_enable) begin
        acq_valid[p] = !st_q.port[p].halt && frm_lock[p];
        acq_data[p] = frm_word[p];
      end else begin
        acq_valid[p] = !st_q.port[p].halt;
        acq_data[p] = st_q.port[p].sync2.data;
      end
    end
  end

  always_comb begin
    st_d = st_q;
    dec_s = addr_dec(paddr);
    dec_a = dec_s;
    if (psel && !penable) begin
      st_d.err = !dec_s[2];
      st_d.rdata = 32'h0000_0000;
      if (dec_s[2] && !dec_s[0]) begin
        st_d.rdata = {24'h00_0000, st_q.port[dec_s[1]].ctrl};
      end else if (dec_s[2]) begin
        st_d.rdata = stat_word(st_q.port[dec_s[1]], frm_lock[dec_s[1]]);
      end
    end
    for (int p = 0; p < 2; p++) begin
      st_d.port[p].sync1 = line_in[p];
      st_d.port[p].sync2 = st_q.port[p].sync1;
      if (!st_q.port[p].ctrl.parity_error_count_enable) begin
        st_d.port[p].pcnt = '0;
      end else if (perr[p] && st_q.port[p].pcnt != '1) begin
        st_d.port[p].pcnt = st_q.port[p].pcnt + 16'h0001;
      end
      if (acq_valid[p] && buf_ready[p]
          && st_q.port[p].ctrl.receive_data_source[1]) begin
        st_d.port[p].tpat = st_q.port[p].tpat + 8'h01;
      end
      if (psel && penable && pwrite && dec_a[2] && dec_a[1] == 1'(p)) begin
        if (!dec_a[0]) begin
          st_d.port[p].ctrl = pwdata[7:0] & `RFC_CTRL_MASK;
        end else if (pwdata[`RFC_STAT_OVF_BIT]) begin
          st_d.port[p].ovf = 1'b0;
        end
      end
      if (!st_q.port[p].ctrl.halt_on_overflow) begin
        st_d.port[p].halt = 1'b0;
      end
      if (acq_valid[p] && !buf_ready[p]) begin
        st_d.port[p].ovf = 1'b1;
        if (st_q.port[p].ctrl.halt_on_overflow) begin
          st_d.port[p].halt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.port[0].ctrl <= `RFC_CTRL_RST;
      st_q.port[1].ctrl <= `RFC_CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_port
    rfc_framer u_framer (
      .pclk(pclk),
      .presetn(presetn),
      .cur(st_q.port[g].sync2.data),
      .pattern(pattern),
      .relock(st_q.port[g].ctrl.framer_relock),
      .desc_en(desc_en[g]),
      .in_frame(frm_lock[g]),
      .word(frm_word[g])
    );

    rfc_buf #(
      .W(8)
    ) u_buf (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(acq_valid[g]),
      .in_ready(buf_ready[g]),
      .in_data(acq_data[g]),
      .out_valid(cap_valid[g]),
      .out_ready(cap_ready[g]),
      .out_data(cap_data[g])
    );
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ctrl_port0_write: assert property (
    psel && penable && pwrite && paddr == `RFC_P0_CTRL
    |=> st_q.port[0].ctrl == ($past(pwdata[7:0]) & `RFC_CTRL_MASK))
    else $error("Port 0 control write not stored.");

  a_ctrl_port1_write: assert property (
    psel && penable && pwrite && paddr == `RFC_P1_CTRL
    |=> st_q.port[1].ctrl == ($past(pwdata[7:0]) & `RFC_CTRL_MASK))
    else $error("Port 1 control write not stored.");

  a_pcnt_held_zero: assert property (
    !st_q.port[0].ctrl.parity_error_count_enable |=> st_q.port[0].pcnt == '0)
    else $error("Parity counter not held at zero.");

  a_pcnt_count_step: assert property (
    st_q.port[0].ctrl.parity_error_count_enable && perr[0]
    && st_q.port[0].pcnt != '1
    |=> st_q.port[0].pcnt == $past(st_q.port[0].pcnt) + 16'h0001)
    else $error("Parity error not counted.");

  a_halt_on_overflow: assert property (
    acq_valid[0] && !buf_ready[0] && st_q.port[0].ctrl.halt_on_overflow
    |=> st_q.port[0].halt && !acq_valid[0])
    else $error("Acquisition went on after overflow.");

  a_lock_gates_data: assert property (
    st_q.port[0].ctrl.framer_lock_enable && !frm_lock[0]
    && !st_q.port[0].ctrl.receive_data_source[1] |-> !acq_valid[0])
    else $error("Data taken while framer unlocked.");

  a_raw_capture_path: assert property (
    !st_q.port[0].ctrl.framer_lock_enable && !st_q.port[0].halt
    && !st_q.port[0].ctrl.receive_data_source[1]
    |-> acq_valid[0] && acq_data[0] == st_q.port[0].sync2.data)
    else $error("Raw word not captured unchanged.");

  a_test_source_count: assert property (
    st_q.port[1].ctrl.receive_data_source[1] && acq_valid[1] && buf_ready[1]
    && !(psel && penable && pwrite)
    |=> st_q.port[1].tpat == $past(acq_data[1]) + 8'h01)
    else $error("Test pattern did not advance.");

  a_pcnt_held_zero1: assert property (
    !st_q.port[1].ctrl.parity_error_count_enable |=> st_q.port[1].pcnt == '0)
    else $error("Port 1 parity counter not held at zero.");

  a_pcnt_count_step1: assert property (
    st_q.port[1].ctrl.parity_error_count_enable && perr[1]
    && st_q.port[1].pcnt != '1
    |=> st_q.port[1].pcnt == $past(st_q.port[1].pcnt) + 16'h0001)
    else $error("Port 1 parity error not counted.");

  a_halt_on_overflow1: assert property (
    acq_valid[1] && !buf_ready[1] && st_q.port[1].ctrl.halt_on_overflow
    |=> st_q.port[1].halt && !acq_valid[1])
    else $error("Port 1 acquisition went on after overflow.");

  a_halt_released: assert property (
    !st_q.port[0].ctrl.halt_on_overflow |=> !st_q.port[0].halt)
    else $error("Halt held although halting is off.");

  a_ovf_sticky: assert property (
    st_q.port[0].ovf
    && !(psel && penable && pwrite && paddr == `RFC_P0_STAT && pwdata[1])
    |=> st_q.port[0].ovf)
    else $error("Overflow flag lost without a clear.");

  a_lock_gates_data1: assert property (
    st_q.port[1].ctrl.framer_lock_enable && !frm_lock[1]
    && !st_q.port[1].ctrl.receive_data_source[1] |-> !acq_valid[1])
    else $error("Port 1 data taken while framer unlocked.");

  a_raw_capture_path1: assert property (
    !st_q.port[1].ctrl.framer_lock_enable && !st_q.port[1].halt
    && !st_q.port[1].ctrl.receive_data_source[1]
    |-> acq_valid[1] && acq_data[1] == st_q.port[1].sync2.data)
    else $error("Port 1 raw word not captured unchanged.");

  a_framed_word_path: assert property (
    st_q.port[0].ctrl.framer_lock_enable && frm_lock[0]
    && !st_q.port[0].halt && !st_q.port[0].ctrl.receive_data_source[1]
    |-> acq_valid[0] && acq_data[0] == frm_word[0])
    else $error("Framed word not taken while in frame.");

  a_test_source_count0: assert property (
    st_q.port[0].ctrl.receive_data_source[1] && acq_valid[0] && buf_ready[0]
    && !(psel && penable && pwrite)
    |=> st_q.port[0].tpat == $past(acq_data[0]) + 8'h01)
    else $error("Port 0 test pattern did not advance.");

  a_buffer_sel_map: assert property (
    onboard_buffer_sel[0] == (st_q.port[0].ctrl.receive_data_source == 2'b01))
    else $error("Onboard buffer select does not follow the source field.");

  a_descr_needs_lock: assert property (
    !st_q.port[0].ctrl.framer_lock_enable |-> !desc_en[0])
    else $error("Descrambler on without framed capture.");

  a_decoder_bypass_map: assert property (
    line_decoder_bypass[0] == (ETH_BUILD && st_q.port[0].ctrl.descramble_disable))
    else $error("Line decoder bypass does not follow bit 4.");

  a_eth_no_descr: assert property (
    ETH_BUILD |-> desc_en == 2'b00)
    else $error("Descrambler on in the Ethernet build.");

  a_relock_drops_frame: assert property (
    st_q.port[0].ctrl.framer_relock |=> !frm_lock[0])
    else $error("Frame held while relock is set.");

  a_pslverr_unmapped: assert property (
    psel && !penable && addr_dec(paddr) == 3'b000 |=> pslverr)
    else $error("Unmapped address not flagged.");

  a_ctrl_read_back: assert property (
    psel && !penable && paddr == `RFC_P0_CTRL
    |=> prdata == {24'h00_0000, $past(st_q.port[0].ctrl)})
    else $error("Port 0 control read back wrong.");

endmodule : rfc_top

/* verif/rfc_line_model.sv */
// Line word source that stands in for the two optical transceivers.
module rfc_line_model import rfc_pkg::*; (
  // Clock
  input wire logic pclk,
  // Fault and pattern controls
  input wire logic [1:0] bad_par,
  input wire logic freeze,
  // Line words toward the block
  output rfc_line_t [1:0] line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h00;

  // An incrementing byte makes each word traceable and holds the pattern.
  always @(posedge pclk) begin
    if (!freeze) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Even parity, inverted on purpose where a fault is asked for.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      line[p].data = cnt_q + 8'(p * 64);
      line[p].parity = (^line[p].data) ^ bad_par[p];
    end
  end
endmodule : rfc_line_model

/* verif/rfc_top_tb.sv */
// Self-checking bench of the two-port receive framing control.
`include "rfc_map.svh"
module rfc_top_tb import rfc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, freeze = 1'b0;
  rfc_line_t [1:0] line_in;
  logic [1:0] cap_valid, onboard_buffer_sel, line_decoder_bypass;
  logic [1:0] cap_ready = 2'b11, bad_par = 2'b00, mon = 2'b00, have = 2'b00;
  logic [1:0][7:0] cap_data, last;
  int err_count = 0, comparisons = 0, seed = 95, n;
  localparam logic [7:0] CTRL [2] = '{`RFC_P0_CTRL, `RFC_P1_CTRL};
  localparam logic [7:0] STAT [2] = '{`RFC_P0_STAT, `RFC_P1_STAT};
  localparam logic [7:0] MODE [5] = '{8'h00, 8'h10, 8'h04, 8'h08, 8'h0C};

  always #2 pclk = ~pclk;

  rfc_top u_rfc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_in(line_in), .cap_valid(cap_valid), .cap_ready(cap_ready),
    .cap_data(cap_data), .onboard_buffer_sel(onboard_buffer_sel),
    .line_decoder_bypass(line_decoder_bypass));
  rfc_line_model u_rfc_line_model (.pclk(pclk), .bad_par(bad_par),
    .freeze(freeze), .line(line_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_count++;
      close_out();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  task automatic wait_lock();
    for (int i = 0; i < 300; i++) begin
      apb(STAT[0], 1'b0, 32'h0, r, e);
      if (r[0] === 1'b1) break;
    end
    chk({31'h0, r[0]}, 32'h1);
  endtask : wait_lock

  // Captured words must run on by one from the last one taken.
  always @(posedge pclk) begin
    for (int p = 0; p < 2; p++) begin
      if (!mon[p]) begin
        have[p] <= 1'b0;
      end else if (cap_valid[p] === 1'b1 && cap_ready[p] === 1'b1) begin
        if (have[p]) chk({24'h0, cap_data[p]}, {24'h0, last[p] + 8'h01});
        last[p] <= cap_data[p];
        have[p] <= 1'b1;
      end
    end
  end

  initial begin
    cyc(4);
    presetn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      apb(CTRL[p], 1'b0, 32'h0, r, e);
      chk(r, 32'h0);
      n = $random(seed);
      wr(CTRL[p], n);
      apb(CTRL[p], 1'b0, 32'h0, r, e);
      chk(r, n & 32'h7F);
      wr(CTRL[p], 32'h0);
    end
    apb(8'h84, 1'b0, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      freeze <= MODE[i][3];
      wr(CTRL[0], MODE[i]);
      wr(CTRL[1], MODE[i]);
      cyc(8);
      mon <= 2'b11;
      cyc(30);
      mon <= 2'b00;
      chk({30'h0, onboard_buffer_sel}, {30'h0, {2{MODE[i][3:2] == 2'b01}}});
      chk({30'h0, line_decoder_bypass}, 32'h0);
    end
    freeze <= 1'b0;
    n = ($random(seed) & 7) + 1;
    wr(CTRL[0], 32'h40);
    cyc(4);
    bad_par <= 2'b11;
    cyc(n);
    bad_par <= 2'b00;
    cyc(8);
    apb(STAT[0], 1'b0, 32'h0, r, e);
    chk({16'h0, r[31:16]}, n);
    apb(STAT[1], 1'b0, 32'h0, r, e);
    chk({16'h0, r[31:16]}, 32'h0);
    wr(CTRL[0], 32'h0);
    apb(STAT[0], 1'b0, 32'h0, r, e);
    chk({16'h0, r[31:16]}, 32'h0);
    wr(CTRL[0], 32'h20);
    cap_ready <= 2'b10;
    cyc(10);
    cap_ready <= 2'b11;
    cyc(6);
    chk({31'h0, cap_valid[0]}, 32'h0);
    apb(STAT[0], 1'b0, 32'h0, r, e);
    chk(r & 32'h6, 32'h6);
    wr(CTRL[0], 32'h0);
    wr(STAT[0], 32'h2);
    apb(STAT[0], 1'b0, 32'h0, r, e);
    chk(r & 32'h6, 32'h0);
    cyc(6);
    chk({31'h0, cap_valid[0]}, 32'h1);
    wr(CTRL[0], 32'h02);
    wait_lock();
    wr(CTRL[0], 32'h03);
    apb(STAT[0], 1'b0, 32'h0, r, e);
    chk({31'h0, r[0]}, 32'h0);
    cyc(6);
    chk({31'h0, cap_valid[0]}, 32'h0);
    wr(CTRL[0], 32'h02);
    wait_lock();
    close_out();
  end
endmodule : rfc_top_tb
